// File: rtr_alarm_cmp.sv
// alarm compare with per-field unconditional match
`timescale 1ns/1ps
module rtr_alarm_cmp (
  // time and alarm values
  rtr_time_if.cmp tm
);
  function automatic logic rtrHit(input logic [7:0] cur, input logic [7:0] alm);
    rtrHit = (alm[7:6] == rtr_pkg::ALM_WILD) || (cur == alm);
  endfunction : rtrHit

  always_comb begin
    tm.match = rtrHit(tm.sec, tm.aSec) && rtrHit(tm.min, tm.aMin)
               && rtrHit(tm.hr, tm.aHr);
  end
endmodule : rtr_alarm_cmp

// File: rtr_bank.sv
// timekeeping and alarm register bank behind an index/data port pair
`timescale 1ns/1ps
// Function
// - no data-port register reads or writes while running from battery only; the index port still works.
// - timekeeping writes ignored while the valid-ram-time flag reads zero.
// - date alarm, month alarm, century sit at programmed ram locations.
// - seconds hold 00-59 bcd or 00-3b binary.
// - seconds alarm takes 00-59 bcd or 00-3b binary as match value.
// - minutes hold 00-59 bcd or 00-3b binary.
// - minutes alarm takes 00-59 bcd or 00-3b binary as match value.
// - alarm field with top bits 11 always matches.
// - 12-hour mode: am 01-12, pm with bit 7 set.
// - 24-hour mode: hours 0-23 bcd or 00-17 binary.
// - host writes index at port 0, moves data at port 1.
module rtr_bank (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // host index/data port
  input  wire logic       hostSel,
  input  wire logic       hostWr,
  input  wire logic       hostRd,
  input  wire logic [7:0] hostWrData,
  output logic      [7:0] hostRdData,
  // power monitor pins
  input  wire logic       onBattery,
  input  wire logic       ramTimeValid,
  // divider chain
  input  wire logic       secTick,
  // alarm
  output logic            alarmFlag,
  output logic            alarmPulse
);
  typedef struct packed {
    logic                                    batt1;
    logic                                    batt2;
    logic                                    vrt1;
    logic                                    vrt2;
    logic [7:0]                              idx;
    logic [7:0]                              sec;
    logic [7:0]                              aSec;
    logic [7:0]                              min;
    logic [7:0]                              aMin;
    logic [7:0]                              hr;
    logic [7:0]                              aHr;
    logic [7:0]                              weekday_value;
    logic [7:0]                              date;
    logic [7:0]                              mon;
    logic [7:0]                              yr;
    logic [7:0]                              ctlA;
    logic [7:0]                              ctlB;
    logic [7:0]                              aDate;
    logic [7:0]                              aMon;
    logic [7:0]                              calendar_hundreds_value;
    logic [7:0]                              locDate;
    logic [7:0]                              locMon;
    logic [7:0]                              locCen;
    logic [rtr_pkg::RAM_WORDS-1:0][7:0]      ram;
    logic [7:0]                              rdData;
    logic                                    tickLate;
    logic                                    almFlag;
    logic                                    almPulse;
  } rtr_state_t;

  rtr_state_t state_q;
  rtr_state_t state_d;
  rtr_time_if tm ();

  rtr_time_step uStep (.tm(tm));
  rtr_alarm_cmp uCmp  (.tm(tm));

  // overlay hit: only honoured inside the general ram range
  function automatic logic rtrOver(input logic [7:0] idx, input logic [7:0] loc);
    rtrOver = (loc >= rtr_pkg::IDX_RAM_LO) && (loc <= rtr_pkg::IDX_RAM_HI) && (idx == loc);
  endfunction : rtrOver

  function automatic logic rtrIsRam(input logic [7:0] idx);
    rtrIsRam = (idx >= rtr_pkg::IDX_RAM_LO) && (idx <= rtr_pkg::IDX_RAM_HI);
  endfunction : rtrIsRam

  assign tm.sec     = state_q.sec;
  assign tm.min     = state_q.min;
  assign tm.hr      = state_q.hr;
  assign tm.aSec    = state_q.aSec;
  assign tm.aMin    = state_q.aMin;
  assign tm.aHr     = state_q.aHr;
  assign tm.binMode = state_q.ctlB[rtr_pkg::CTLB_BIN_BIT];
  assign tm.h24     = state_q.ctlB[rtr_pkg::CTLB_H24_BIT];

  logic       access;
  logic       wrTime;
  logic       dataWr;
  logic       dataRd;
  logic [6:0] ramIdx;
  logic [7:0] rdVal;

  always_comb begin
    state_d = state_q;
    // pin inputs from the power monitor are asynchronous
    state_d.batt1 = onBattery;
    state_d.batt2 = state_q.batt1;
    state_d.vrt1  = ramTimeValid;
    state_d.vrt2  = state_q.vrt1;
    access = !state_q.batt2;
    wrTime = access && state_q.vrt2;
    dataWr = hostWr && hostSel && access;
    dataRd = hostRd && hostSel && access;
    ramIdx = 7'(state_q.idx - rtr_pkg::IDX_RAM_LO);
    state_d.almPulse = 1'b0;
    state_d.tickLate = 1'b0;

    // counters advance once a second unless software holds them
    if (secTick && !state_q.ctlB[rtr_pkg::CTLB_SET_BIT]) begin
      state_d.sec      = tm.nxtSec;
      state_d.min      = tm.nxtMin;
      state_d.hr       = tm.nxtHr;
      state_d.tickLate = 1'b1;
    end

    // compare after the counters settled, one cycle behind the tick
    if (state_q.tickLate && tm.match) begin
      state_d.almPulse = 1'b1;
    end

    if (hostWr && !hostSel) begin
      state_d.idx = hostWrData;
    end

    // read data mux
    rdVal = 8'h00;
    if (rtrOver(state_q.idx, state_q.locDate)) rdVal = state_q.aDate;
    else if (rtrOver(state_q.idx, state_q.locMon)) rdVal = state_q.aMon;
    else if (rtrOver(state_q.idx, state_q.locCen)) rdVal = state_q.calendar_hundreds_value;
    else if (rtrIsRam(state_q.idx)) rdVal = state_q.ram[ramIdx];
    else begin
      unique case (state_q.idx)
        rtr_pkg::IDX_SEC:      rdVal = state_q.sec;
        rtr_pkg::IDX_ASEC:     rdVal = state_q.aSec;
        rtr_pkg::IDX_MIN:      rdVal = state_q.min;
        rtr_pkg::IDX_AMIN:     rdVal = state_q.aMin;
        rtr_pkg::IDX_HR:       rdVal = state_q.hr;
        rtr_pkg::IDX_AHR:      rdVal = state_q.aHr;
        rtr_pkg::IDX_DOW:      rdVal = state_q.weekday_value;
        rtr_pkg::IDX_DATE:     rdVal = state_q.date;
        rtr_pkg::IDX_MON:      rdVal = state_q.mon;
        rtr_pkg::IDX_YR:       rdVal = state_q.yr;
        rtr_pkg::IDX_CTLA:     rdVal = state_q.ctlA;
        rtr_pkg::IDX_CTLB:     rdVal = state_q.ctlB;
        rtr_pkg::IDX_FLAGS:    rdVal[rtr_pkg::FLAG_ALM_BIT] = state_q.almFlag;
        rtr_pkg::IDX_PWR:      rdVal[rtr_pkg::PWR_VRT_BIT] = state_q.vrt2;
        rtr_pkg::IDX_LOC_DATE: rdVal = state_q.locDate;
        rtr_pkg::IDX_LOC_MON:  rdVal = state_q.locMon;
        rtr_pkg::IDX_LOC_CEN:  rdVal = state_q.locCen;
        default:               rdVal = 8'h00;
      endcase
    end

    if (hostRd) begin
      if (!hostSel) state_d.rdData = state_q.idx;
      else if (dataRd) state_d.rdData = rdVal;
      else state_d.rdData = 8'h00;
    end

    // reading the flag register clears it; a new alarm in the same cycle wins
    if (dataRd && state_q.idx == rtr_pkg::IDX_FLAGS) state_d.almFlag = 1'b0;
    if (state_d.almPulse) state_d.almFlag = 1'b1;

    // host writes win over the tick in the same cycle
    if (dataWr) begin
      if (rtrOver(state_q.idx, state_q.locDate)) begin
        if (wrTime) state_d.aDate = hostWrData;
      end else if (rtrOver(state_q.idx, state_q.locMon)) begin
        if (wrTime) state_d.aMon = hostWrData;
      end else if (rtrOver(state_q.idx, state_q.locCen)) begin
        if (wrTime) state_d.calendar_hundreds_value = hostWrData;
      end else if (rtrIsRam(state_q.idx)) begin
        state_d.ram[ramIdx] = hostWrData;
      end else begin
        unique case (state_q.idx)
          rtr_pkg::IDX_SEC:      if (wrTime) state_d.sec = hostWrData;
          rtr_pkg::IDX_ASEC:     if (wrTime) state_d.aSec = hostWrData;
          rtr_pkg::IDX_MIN:      if (wrTime) state_d.min = hostWrData;
          rtr_pkg::IDX_AMIN:     if (wrTime) state_d.aMin = hostWrData;
          rtr_pkg::IDX_HR:       if (wrTime) state_d.hr = hostWrData;
          rtr_pkg::IDX_AHR:      if (wrTime) state_d.aHr = hostWrData;
          rtr_pkg::IDX_DOW:      if (wrTime) state_d.weekday_value = hostWrData;
          rtr_pkg::IDX_DATE:     if (wrTime) state_d.date = hostWrData;
          rtr_pkg::IDX_MON:      if (wrTime) state_d.mon = hostWrData;
          rtr_pkg::IDX_YR:       if (wrTime) state_d.yr = hostWrData;
          rtr_pkg::IDX_CTLA:     if (wrTime) state_d.ctlA[6:0] = hostWrData[6:0];
          rtr_pkg::IDX_CTLB:     if (wrTime) state_d.ctlB = hostWrData;
          rtr_pkg::IDX_LOC_DATE: state_d.locDate = hostWrData;
          rtr_pkg::IDX_LOC_MON:  state_d.locMon = hostWrData;
          rtr_pkg::IDX_LOC_CEN:  state_d.locCen = hostWrData;
          default:               state_d.idx = state_d.idx;
        endcase
      end
    end

    // divider and rate fields held clear until time is marked valid
    if (!state_q.vrt2) state_d.ctlA[6:0] = 7'h00;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= '0;
      state_q.ctlA <= rtr_pkg::RST_CTLA;
    end else begin
      state_q <= state_d;
    end
  end

  assign hostRdData = state_q.rdData;
  assign alarmFlag  = state_q.almFlag;
  assign alarmPulse = state_q.almPulse;

  logic tickRun;
  assign tickRun = secTick && !state_q.ctlB[rtr_pkg::CTLB_SET_BIT];

  AST_BATT_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostRd && hostSel && state_q.batt2 |=> hostRdData == 8'h00)
    else $error("read on battery returned data");

  AST_BATT_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostWr && hostSel && state_q.batt2 && state_q.idx == rtr_pkg::IDX_SEC && !tickRun
    |=> $stable(state_q.sec))
    else $error("write on battery changed seconds");

  AST_VRT_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostWr && hostSel && !state_q.vrt2 && state_q.idx == rtr_pkg::IDX_SEC && !tickRun
    |=> $stable(state_q.sec))
    else $error("write with time invalid changed seconds");

  AST_OVERLAY_CEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dataWr && wrTime && rtrOver(state_q.idx, state_q.locCen)
    && !rtrOver(state_q.idx, state_q.locDate) && !rtrOver(state_q.idx, state_q.locMon)
    |=> state_q.calendar_hundreds_value == $past(hostWrData) && $stable(state_q.ram))
    else $error("century overlay write missed");

  AST_SEC_BCD_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tickRun && !dataWr && !tm.binMode && state_q.sec == 8'h59
    |=> state_q.sec == 8'h00 ##1 state_q.sec == 8'h00 || tickRun || hostWr)
    else $error("bcd seconds did not wrap at 59");

  AST_MIN_BIN_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tickRun && !dataWr && tm.binMode && state_q.sec == 8'h3b && state_q.min == 8'h3b
    |=> state_q.min == 8'h00 && state_q.sec == 8'h00)
    else $error("binary minutes did not wrap at 3b");

  AST_H12_NOON: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tickRun && !dataWr && !tm.binMode && !tm.h24 && state_q.sec == 8'h59
    && state_q.min == 8'h59 && state_q.hr == 8'h11
    |=> state_q.hr == 8'h92)
    else $error("11 am did not step to 12 pm");

  AST_H24_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tickRun && !dataWr && tm.binMode && tm.h24 && state_q.sec == 8'h3b
    && state_q.min == 8'h3b && state_q.hr == 8'h17
    |=> state_q.hr == 8'h00)
    else $error("binary 24 hour did not wrap at 17");

  AST_WILD_ALARM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q.tickLate && state_q.aSec[7:6] == 2'b11 && state_q.aMin[7:6] == 2'b11
    && state_q.aHr[7:6] == 2'b11
    |=> alarmPulse ##1 alarmFlag || (hostRd && hostSel))
    else $error("wildcard alarm did not fire");

  AST_ALARM_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    alarmPulse |-> $past(state_q.tickLate) && alarmFlag)
    else $error("alarm pulse without a tick");

  AST_INDEX_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostWr && !hostSel |=> state_q.idx == $past(hostWrData))
    else $error("index write not taken");
endmodule : rtr_bank

// File: rtr_pkg.sv
// constants for the rtc timekeeping and alarm register bank
package rtr_pkg;
  // index locations
  localparam logic [7:0] IDX_SEC      = 8'h00;
  localparam logic [7:0] IDX_ASEC     = 8'h01;
  localparam logic [7:0] IDX_MIN      = 8'h02;
  localparam logic [7:0] IDX_AMIN     = 8'h03;
  localparam logic [7:0] IDX_HR       = 8'h04;
  localparam logic [7:0] IDX_AHR      = 8'h05;
  localparam logic [7:0] IDX_DOW      = 8'h06;
  localparam logic [7:0] IDX_DATE     = 8'h07;
  localparam logic [7:0] IDX_MON      = 8'h08;
  localparam logic [7:0] IDX_YR       = 8'h09;
  localparam logic [7:0] IDX_CTLA     = 8'h0a;
  localparam logic [7:0] IDX_CTLB     = 8'h0b;
  localparam logic [7:0] IDX_FLAGS    = 8'h0c;
  localparam logic [7:0] IDX_PWR      = 8'h0d;
  localparam logic [7:0] IDX_RAM_LO   = 8'h0e;
  localparam logic [7:0] IDX_RAM_HI   = 8'h7f;
  localparam logic [7:0] IDX_LOC_DATE = 8'hf1;
  localparam logic [7:0] IDX_LOC_MON  = 8'hf2;
  localparam logic [7:0] IDX_LOC_CEN  = 8'hf3;
  localparam int         RAM_WORDS    = 114;
  // reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_CTLA     = 8'h20;
  // field positions
  localparam int         CTLB_SET_BIT = 7;
  localparam int         CTLB_BIN_BIT = 2;
  localparam int         CTLB_H24_BIT = 1;
  localparam int         FLAG_ALM_BIT = 5;
  localparam int         PWR_VRT_BIT  = 7;
  localparam int         HR_PM_BIT    = 7;
  localparam logic [1:0] ALM_WILD     = 2'b11;
  // counter limits
  localparam logic [7:0] TOP_MS_BCD   = 8'h59;
  localparam logic [7:0] TOP_MS_BIN   = 8'h3b;
  localparam logic [7:0] TOP_H24_BCD  = 8'h23;
  localparam logic [7:0] TOP_H24_BIN  = 8'h17;
  localparam logic [6:0] H12_TOP_BCD  = 7'h12;
  localparam logic [6:0] H12_TOP_BIN  = 7'h0c;
  localparam logic [6:0] H12_ELV_BCD  = 7'h11;
  localparam logic [6:0] H12_ELV_BIN  = 7'h0b;
  localparam logic [6:0] H12_FIRST    = 7'h01;
endpackage : rtr_pkg

// File: rtr_time_if.sv
// interface between the register bank and its time helpers
`timescale 1ns/1ps
interface rtr_time_if;
  logic [7:0] sec;
  logic [7:0] min;
  logic [7:0] hr;
  logic [7:0] aSec;
  logic [7:0] aMin;
  logic [7:0] aHr;
  logic       binMode;
  logic       h24;
  logic [7:0] nxtSec;
  logic [7:0] nxtMin;
  logic [7:0] nxtHr;
  logic       match;
  modport owner (output sec, min, hr, aSec, aMin, aHr, binMode, h24,
                 input nxtSec, nxtMin, nxtHr, match);
  modport calc  (input sec, min, hr, binMode, h24,
                 output nxtSec, nxtMin, nxtHr);
  modport cmp   (input sec, min, hr, aSec, aMin, aHr, output match);
endinterface : rtr_time_if

// File: rtr_time_step.sv
// next-second value of seconds, minutes and hours
`timescale 1ns/1ps
module rtr_time_step (
  // time values
  rtr_time_if.calc tm
);
  function automatic logic [7:0] rtrInc(input logic [7:0] v, input logic bin);
    if (bin || v[3:0] != 4'h9) rtrInc = v + 8'h01;
    else rtrInc = {v[7:4] + 4'h1, 4'h0};
  endfunction : rtrInc

  logic [7:0] msTop;
  logic [7:0] hrTop;
  logic [6:0] h12Top;
  logic [6:0] h12Elv;
  logic [6:0] hLow;
  logic [7:0] hrInc;
  logic [7:0] hStep;
  logic       secWrap;
  logic       minWrap;

  always_comb begin
    msTop   = tm.binMode ? rtr_pkg::TOP_MS_BIN : rtr_pkg::TOP_MS_BCD;
    hrTop   = tm.binMode ? rtr_pkg::TOP_H24_BIN : rtr_pkg::TOP_H24_BCD;
    h12Top  = tm.binMode ? rtr_pkg::H12_TOP_BIN : rtr_pkg::H12_TOP_BCD;
    h12Elv  = tm.binMode ? rtr_pkg::H12_ELV_BIN : rtr_pkg::H12_ELV_BCD;
    hLow    = tm.hr[6:0];
    hStep   = rtrInc({1'b0, hLow}, tm.binMode);
    secWrap = (tm.sec == msTop);
    minWrap = (tm.min == msTop);
    if (tm.h24) begin
      hrInc = (tm.hr == hrTop) ? 8'h00 : rtrInc(tm.hr, tm.binMode);
    end else if (hLow == h12Top) begin
      hrInc = {tm.hr[rtr_pkg::HR_PM_BIT], rtr_pkg::H12_FIRST};
    end else if (hLow == h12Elv) begin
      hrInc = {~tm.hr[rtr_pkg::HR_PM_BIT], h12Top};
    end else begin
      hrInc = {tm.hr[rtr_pkg::HR_PM_BIT], hStep[6:0]};
    end
    tm.nxtSec = secWrap ? 8'h00 : rtrInc(tm.sec, tm.binMode);
    tm.nxtMin = secWrap ? (minWrap ? 8'h00 : rtrInc(tm.min, tm.binMode)) : tm.min;
    tm.nxtHr  = (secWrap && minWrap) ? hrInc : tm.hr;
  end
endmodule : rtr_time_step

// File: tb_top.sv
// self-checking bench for the rtc timekeeping and alarm register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
  // clock and reset
  logic       sys_clk;
  logic       rst_n;
  // host port
  logic       hostSel;
  logic       hostWr;
  logic       hostRd;
  logic [7:0] hostWrData;
  logic [7:0] hostRdData;
  // power pins, divider, alarm
  logic       onBattery;
  logic       ramTimeValid;
  logic       secTick;
  logic       alarmFlag;
  logic       alarmPulse;
  // bench state
  int         fail_count;
  int         cmp_count;
  logic [7:0] rdVal;

  rtr_bank rtr_bank_inst (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .hostSel      (hostSel),
    .hostWr       (hostWr),
    .hostRd       (hostRd),
    .hostWrData   (hostWrData),
    .hostRdData   (hostRdData),
    .onBattery    (onBattery),
    .ramTimeValid (ramTimeValid),
    .secTick      (secTick),
    .alarmFlag    (alarmFlag),
    .alarmPulse   (alarmPulse)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask : step

  // idle cycle after each strobe so a strobe is never dropped and raised in one step
  task automatic portWr(input logic sel, input logic [7:0] d);
    hostSel    = sel;
    hostWrData = d;
    hostWr     = 1'b1;
    step(1);
    hostWr     = 1'b0;
    step(1);
  endtask : portWr

  task automatic regWr(input logic [7:0] idx, input logic [7:0] d);
    portWr(1'b0, idx);
    portWr(1'b1, d);
  endtask : regWr

  task automatic regRd(input logic [7:0] idx);
    portWr(1'b0, idx);
    hostSel = 1'b1;
    hostRd  = 1'b1;
    step(1);
    hostRd  = 1'b0;
    step(1);
    rdVal   = hostRdData;
  endtask : regRd

  task automatic chkRd(input logic [7:0] idx, input logic [7:0] exp);
    regRd(idx);
    `CHK(rdVal, exp)
  endtask : chkRd

  task automatic tick();
    secTick = 1'b1;
    step(1);
    secTick = 1'b0;
  endtask : tick

  task automatic setTime(input logic [7:0] b, input logic [7:0] s, input logic [7:0] m,
                         input logic [7:0] h);
    regWr(rtr_pkg::IDX_CTLB, b);
    regWr(rtr_pkg::IDX_SEC, s);
    regWr(rtr_pkg::IDX_MIN, m);
    regWr(rtr_pkg::IDX_HR, h);
  endtask : setTime

  // one tick from a set time, then the three counters read back
  task automatic roll(input logic [7:0] b, input logic [7:0] s, input logic [7:0] m,
                      input logic [7:0] h, input logic [7:0] es, input logic [7:0] em,
                      input logic [7:0] eh);
    setTime(b, s, m, h);
    tick();
    step(1);
    chkRd(rtr_pkg::IDX_SEC, es);
    chkRd(rtr_pkg::IDX_MIN, em);
    chkRd(rtr_pkg::IDX_HR, eh);
  endtask : roll

  // time 05:20:10 bcd 24h ticks to 05:20:11, compared against the given alarm
  task automatic alarmCase(input logic [7:0] as, input logic [7:0] am, input logic [7:0] ah,
                           input logic hit);
    setTime(8'h02, 8'h10, 8'h20, 8'h05);
    regWr(rtr_pkg::IDX_ASEC, as);
    regWr(rtr_pkg::IDX_AMIN, am);
    regWr(rtr_pkg::IDX_AHR, ah);
    regRd(rtr_pkg::IDX_FLAGS);
    tick();
    step(1);
    `CHK(alarmPulse, hit)
    `CHK(alarmFlag, hit)
    step(1);
    `CHK(alarmPulse, 1'b0)
    chkRd(rtr_pkg::IDX_FLAGS, hit ? 8'h20 : 8'h00);
    `CHK(alarmFlag, 1'b0)
  endtask : alarmCase

  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // whole run is under a thousand cycles; this cuts a hang short
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end

  initial begin
    fail_count   = 0;
    cmp_count    = 0;
    rst_n        = 1'b0;
    hostSel      = 1'b0;
    hostWr       = 1'b0;
    hostRd       = 1'b0;
    hostWrData   = 8'h00;
    onBattery    = 1'b0;
    ramTimeValid = 1'b1;
    secTick      = 1'b0;
    step(4);
    rst_n = 1'b1;
    step(3);
    // reset values
    for (int i = 0; i < 6; i++) begin
      chkRd(8'(i), rtr_pkg::RST_BYTE);
    end
    // rate bits cleared until the synced valid flag first rises
    chkRd(rtr_pkg::IDX_CTLA, 8'h00);
    chkRd(rtr_pkg::IDX_PWR, 8'h80);
    // every timekeeping location holds its own byte
    for (int i = 0; i < 10; i++) begin
      regWr(8'(i), 8'(i + 1));
    end
    for (int i = 0; i < 10; i++) begin
      chkRd(8'(i), 8'(i + 1));
    end
    // read-only and unmapped places
    regWr(rtr_pkg::IDX_FLAGS, 8'hff);
    chkRd(rtr_pkg::IDX_FLAGS, 8'h00);
    regWr(rtr_pkg::IDX_PWR, 8'h00);
    chkRd(rtr_pkg::IDX_PWR, 8'h80);
    regWr(8'h80, 8'h5a);
    chkRd(8'h80, 8'h00);
    // flag low: timekeeping writes dropped, general ram still written
    ramTimeValid = 1'b0;
    step(3);
    regWr(rtr_pkg::IDX_SEC, 8'h33);
    regWr(8'h20, 8'h44);
    chkRd(rtr_pkg::IDX_SEC, 8'h01);
    chkRd(8'h20, 8'h44);
    chkRd(rtr_pkg::IDX_PWR, 8'h00);
    ramTimeValid = 1'b1;
    step(3);
    // battery only: no data-port access
    onBattery = 1'b1;
    step(3);
    regWr(rtr_pkg::IDX_SEC, 8'h45);
    chkRd(rtr_pkg::IDX_SEC, 8'h00);
    onBattery = 1'b0;
    step(3);
    chkRd(rtr_pkg::IDX_SEC, 8'h01);
    // overlays follow their locations; the ram byte beneath is untouched
    for (int k = 0; k < 3; k++) begin
      regWr(rtr_pkg::IDX_LOC_DATE + 8'(k), 8'h40 + 8'(k));
      regWr(8'h40 + 8'(k), 8'h60 + 8'(k));
      regWr(rtr_pkg::IDX_LOC_DATE + 8'(k), 8'h00);
      chkRd(8'h40 + 8'(k), 8'h00);
      regWr(rtr_pkg::IDX_LOC_DATE + 8'(k), rtr_pkg::IDX_RAM_HI);
      chkRd(rtr_pkg::IDX_LOC_DATE + 8'(k), rtr_pkg::IDX_RAM_HI);
      chkRd(rtr_pkg::IDX_RAM_HI, 8'h60 + 8'(k));
      regWr(rtr_pkg::IDX_LOC_DATE + 8'(k), 8'h00);
    end
    // counter ranges and carries in each format and hour mode
    roll(8'h02, 8'h59, 8'h59, 8'h23, 8'h00, 8'h00, 8'h00);
    roll(8'h02, 8'h09, 8'h58, 8'h09, 8'h10, 8'h58, 8'h09);
    roll(8'h06, 8'h3b, 8'h3b, 8'h17, 8'h00, 8'h00, 8'h00);
    roll(8'h06, 8'h09, 8'h3a, 8'h09, 8'h0a, 8'h3a, 8'h09);
    roll(8'h06, 8'h3b, 8'h09, 8'h09, 8'h00, 8'h0a, 8'h09);
    roll(8'h00, 8'h59, 8'h59, 8'h11, 8'h00, 8'h00, 8'h92);
    roll(8'h00, 8'h59, 8'h59, 8'h92, 8'h00, 8'h00, 8'h81);
    roll(8'h00, 8'h59, 8'h59, 8'h12, 8'h00, 8'h00, 8'h01);
    roll(8'h04, 8'h3b, 8'h3b, 8'h8b, 8'h00, 8'h00, 8'h0c);
    roll(8'h04, 8'h3b, 8'h3b, 8'h0c, 8'h00, 8'h00, 8'h01);
    // hold bit set: a tick leaves the counters alone
    roll(8'h82, 8'h10, 8'h20, 8'h05, 8'h10, 8'h20, 8'h05);
    // alarm compare with and without unconditional fields
    alarmCase(8'h11, 8'h20, 8'h05, 1'b1);
    alarmCase(8'h12, 8'h20, 8'h05, 1'b0);
    alarmCase(8'h11, 8'h21, 8'h05, 1'b0);
    alarmCase(8'h11, 8'h20, 8'h06, 1'b0);
    alarmCase(8'hc5, 8'h20, 8'h05, 1'b1);
    alarmCase(8'h11, 8'hff, 8'h05, 1'b1);
    alarmCase(8'h11, 8'h20, 8'hc0, 1'b1);
    alarmCase(8'h11, 8'ha0, 8'h05, 1'b0);
    alarmCase(8'hc0, 8'hc0, 8'hc0, 1'b1);
    wrap_up();
  end
endmodule : tb_top
